// ---- verilog/efm_pkg.sv ----
// Shared constants, field layouts and state types of the drive monitor.
// Assumes a 125 MHz core clock and a word-wide plain register port.
package efm_pkg;
	// Clock and time base
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int MS_PER_WIN_UNIT = 10; // One window unit is 0.01 s
	localparam int HW_STALL_MS = 50; // Pulse silence that means open wire
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ENC = 8'h04;
	localparam logic [7:0] ADDR_MOTOR = 8'h08;
	localparam logic [7:0] ADDR_DEV = 8'h0C;
	localparam logic [7:0] ADDR_FLUX = 8'h10;
	localparam logic [7:0] ADDR_REEST = 8'h14;
	localparam logic [7:0] ADDR_TRIP = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam logic [7:0] ADDR_STATE = 8'h24;
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_TUNE_LSB = 2;
	localparam int CTRL_HWCHK_BIT = 4;
	localparam int HI_LSB = 16; // Second field of a word
	localparam int FLUX_PULSE_LSB = 8;
	// Mode encodings
	localparam logic [1:0] MODE_SPEED = 2'h0;
	localparam logic [1:0] TUNE_NONE = 2'h0;
	// Setting ranges and reset values
	localparam logic [9:0] WIN_DEF = 10'h000;
	localparam logic [9:0] WIN_MAX = 10'h3E8;
	localparam logic [8:0] RATIO_DEF = 9'h0FA; // Tenths of a percent
	localparam logic [8:0] RATIO_MAX = 9'h1F4;
	localparam logic [7:0] SLIP_MIN = 8'h0A;
	localparam logic [7:0] SLIP_MAX = 8'hFA;
	localparam logic [7:0] SLIP_DEF = 8'h28;
	localparam logic [11:0] BASE_DEF = 12'h708;
	localparam logic [6:0] LEVEL_DEF = 7'h1E;
	localparam logic [6:0] LEVEL_MAX = 7'h64;
	localparam logic [13:0] DTIME_DEF = 14'h05DC;
	localparam logic [13:0] DTIME_MAX = 14'h270F;
	localparam logic [4:0] REP_MIN = 5'h01;
	localparam logic [4:0] REP_MAX = 5'h1E;
	localparam logic [7:0] PULSE_MIN = 8'h32;
	localparam logic [7:0] PULSE_MAX = 8'hC8;
	localparam logic [7:0] PULSE_DEF = 8'h50;
	localparam logic [7:0] CURR_MIN = 8'h0A;
	localparam logic [7:0] CURR_MAX = 8'h96;
	localparam logic [7:0] CURR_DEF = 8'h46;
	localparam logic [15:0] REEST_DEF = 16'h0064;
	localparam logic [3:0] TRIP_DEF = 4'hE;
	// Status bits
	localparam int ST_OUT_PH = 0;
	localparam int ST_IN_PH = 1;
	localparam int ST_MAG = 2;
	localparam int ST_DEV = 3;
	localparam int ST_ENC_SW = 4;
	localparam int ST_ENC_HW = 5;
	localparam int ST_FLUX_DONE = 6;
	localparam int ST_W = 7;
	// Encoder plausibility sequence
	typedef enum logic [2:0] {
		ENC_IDLE, ENC_WAIT_SLIP, ENC_TIMING, ENC_CHECK, ENC_DONE
	} enc_state_t;
	// Flux estimation sequence
	typedef enum logic {FLX_IDLE, FLX_BUSY} flux_state_t;
	// Settings written by software
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] tune;
		logic hw_chk;
		logic [9:0] window;
		logic [8:0] ratio;
		logic [7:0] slip;
		logic [11:0] base;
		logic [6:0] level;
		logic [13:0] dtime;
		logic [4:0] repeats;
		logic [15:0] reest;
		logic [3:0] trip_mask;
		logic [ST_W-1:0] irq_mask;
	} cfg_t;
	// Command to the flux estimation engine
	typedef struct packed {
		logic start;
		logic [4:0] repeats;
		logic [7:0] pulse_size;
		logic [7:0] current_pct;
	} flux_cmd_t;
	// Whole state of the monitor
	typedef struct packed {
		cfg_t cfg;
		flux_cmd_t flux;
		logic [16:0] div;
		logic a_s1, a_s2, a_s3;
		logic b_s1, b_s2, b_s3;
		logic run_d;
		enc_state_t enc_st;
		logic [13:0] enc_cnt;
		logic [13:0] dev_cnt;
		logic dev_fired;
		logic [13:0] hw_cnt;
		flux_state_t flx_st;
		logic flux_init;
		logic [15:0] run_cnt;
		logic [4:0] passes;
		logic [ST_W-1:0] status;
		logic trip;
		logic irq;
		logic [31:0] rdata;
	} state_t;
endpackage

// ---- verilog/encoder_fault_speed_deviation_monitor.sv ----
// Encoder plausibility, speed deviation, trip mask and flux re-estimation.
// Run, speed and fault inputs come from logic on core_clk; encoder pins
// are asynchronous and are synchronised here.

// Operation
// - Arm only: speed mode, no tuning, window set
// - Window setting zero to ten seconds, default off
// - After window, compare speed against target ratio
// - Slow or reversed speed declares encoder fault
// - Run loss or deceleration abandons the check
// - Check once per run, never while tuning
// - Activate at target twice rated slip
// - Hardware check watches pulse activity for opens
// - Deviation above level too long raises error
// - Deviation time in ms, default 1500
// - Four-bit trip mask, default 1110
// - Flux estimate first run, then every N runs
// - Repeat flux detection configured times
// - Flux detection pulse size 50 to 200
// - Flux detection current 10 to 150 percent
module encoder_fault_speed_deviation_monitor
	import efm_pkg::*;
#(
	parameter int TICK_CYCLES = CYC_PER_MS, // Cycles per millisecond
	parameter int STALL_MS = HW_STALL_MS // Open-wire silence
) (
	input logic core_clk,
	input logic rst_b,
	input logic [7:0] bus_addr,
	input logic [31:0] bus_wdata,
	input logic bus_wr,
	input logic bus_rd,
	output logic [31:0] bus_rdata,
	input logic run_cmd,
	input logic accel_active,
	input logic signed [15:0] target_speed,
	input logic signed [15:0] speed_cmd,
	input logic signed [15:0] speed_meas,
	input logic enc_a,
	input logic enc_b,
	input logic out_phase_loss,
	input logic in_phase_loss,
	input logic mag_detect_err,
	input logic flux_pass_done,
	output flux_cmd_t flux_cmd,
	output logic drive_trip,
	output logic irq
);
	localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
	localparam logic [13:0] STALL_LAST = 14'(STALL_MS - 1);
	localparam logic [13:0] WIN_UNIT = 14'(MS_PER_WIN_UNIT);

	state_t s; // Registered state
	state_t n; // Next state
	logic tick; // One-millisecond enable
	logic armed; // Encoder check may start
	logic [15:0] tgt_abs; // Target magnitude
	logic slip_ok; // Target beyond twice slip
	logic shortfall; // Speed behind or reversed
	logic excess; // Deviation above level
	logic run_rise; // New run command

	// Clamp a setting into its legal range
	function automatic logic [15:0] clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// Magnitude of a signed speed
	function automatic logic [15:0] mag(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	// Shared decodes of the current state
	always_comb begin
		tick = (s.div == TICK_LAST);
		armed = (s.cfg.mode == MODE_SPEED) && (s.cfg.tune == TUNE_NONE)
			&& (s.cfg.window != WIN_DEF);
		tgt_abs = mag(target_speed);
		slip_ok = {1'b0, tgt_abs} >= {8'h00, s.cfg.slip, 1'b0};
		// Speed along the target sign, scaled against target ratio
		shortfall = (32'(target_speed[15] ? -speed_meas : speed_meas)
			* 32'sd1000) < $signed(32'(tgt_abs) * 32'(s.cfg.ratio));
		excess = (32'(mag(16'(speed_cmd - speed_meas))) * 32'd100)
			> (32'(s.cfg.base) * 32'(s.cfg.level));
		run_rise = run_cmd && !s.run_d;
	end

	// Next state of the whole monitor
	always_comb begin
		logic [ST_W-1:0] ev; // Events of this cycle
		logic [ST_W-1:0] w1c; // Bits cleared by software
		logic edge_seen; // Encoder pulse activity
		logic start_est; // Begin a flux estimation
		ev = '0;
		w1c = '0;
		edge_seen = (s.a_s2 ^ s.a_s3) || (s.b_s2 ^ s.b_s3);
		start_est = 1'b0;
		n = s;
		n.flux.start = 1'b0;
		n.rdata = '0;
		// Millisecond divider
		n.div = tick ? '0 : s.div + 17'h00001;
		// Encoder pin synchronisers and edge history
		n.a_s1 = enc_a;
		n.a_s2 = s.a_s1;
		n.a_s3 = s.a_s2;
		n.b_s1 = enc_b;
		n.b_s2 = s.b_s1;
		n.b_s3 = s.b_s2;
		n.run_d = run_cmd;
		// Outside fault inputs
		ev[ST_OUT_PH] = out_phase_loss;
		ev[ST_IN_PH] = in_phase_loss;
		ev[ST_MAG] = mag_detect_err;

		// Encoder plausibility sequence, once per run
		case (s.enc_st)
			ENC_IDLE: begin
				n.enc_cnt = '0;
				if (run_rise && armed) begin
					n.enc_st = ENC_WAIT_SLIP;
				end
			end
			ENC_WAIT_SLIP: begin
				if (!run_cmd || !accel_active) begin
					n.enc_st = ENC_DONE;
				end else if (slip_ok) begin
					n.enc_st = ENC_TIMING;
				end
			end
			ENC_TIMING: begin
				if (!run_cmd || !accel_active) begin
					n.enc_st = ENC_DONE;
				end else if (tick) begin
					// Window counted in ms, ten per setting unit
					if (s.enc_cnt + 14'h0001 >= 14'(s.cfg.window) * WIN_UNIT) begin
						n.enc_st = ENC_CHECK;
					end
					n.enc_cnt = s.enc_cnt + 14'h0001;
				end
			end
			ENC_CHECK: begin
				// Single comparison while still accelerating
				n.enc_st = ENC_DONE;
				if (run_cmd && accel_active && shortfall) begin
					ev[ST_ENC_SW] = 1'b1;
				end
			end
			ENC_DONE: begin
				// Wait for the run to end before rearming
				if (!run_cmd) begin
					n.enc_st = ENC_IDLE;
				end
			end
			default: begin
				n.enc_st = ENC_IDLE;
			end
		endcase
		// Tuning selected: no check at all
		// An idle sequence stays idle, so tuning never looks like arming
		if (s.cfg.tune != TUNE_NONE) begin
			n.enc_st = (run_cmd && s.enc_st != ENC_IDLE) ? ENC_DONE
				: ENC_IDLE;
		end

		// Speed deviation persistence
		if (!excess) begin
			n.dev_cnt = '0;
			n.dev_fired = 1'b0;
		end else if (!s.dev_fired) begin
			if (s.dev_cnt >= s.cfg.dtime) begin
				ev[ST_DEV] = 1'b1;
				n.dev_fired = 1'b1;
			end else if (tick) begin
				n.dev_cnt = s.dev_cnt + 14'h0001;
			end
		end

		// Hardware open-wire watch on pulse activity
		if (!s.cfg.hw_chk || !run_cmd || !slip_ok || edge_seen) begin
			n.hw_cnt = '0;
		end else if (tick && s.hw_cnt <= STALL_LAST) begin
			n.hw_cnt = s.hw_cnt + 14'h0001;
			ev[ST_ENC_HW] = (s.hw_cnt == STALL_LAST);
		end

		// Flux estimation scheduling by run count
		if (run_rise) begin
			if (!s.flux_init) begin
				start_est = 1'b1;
				n.flux_init = 1'b1;
			end else if (s.cfg.reest != '0
				&& s.run_cnt + 16'h0001 >= s.cfg.reest) begin
				start_est = 1'b1;
				n.run_cnt = '0;
			end else begin
				n.run_cnt = s.run_cnt + 16'h0001;
			end
		end
		case (s.flx_st)
			FLX_IDLE: begin
				if (start_est) begin
					n.flx_st = FLX_BUSY;
					n.passes = '0;
					n.flux.start = 1'b1;
				end
			end
			FLX_BUSY: begin
				if (flux_pass_done) begin
					if (s.passes + 5'h01 >= s.cfg.repeats) begin
						n.flx_st = FLX_IDLE;
						ev[ST_FLUX_DONE] = 1'b1;
					end else begin
						n.passes = s.passes + 5'h01;
						n.flux.start = 1'b1;
					end
				end
			end
			default: begin
				n.flx_st = FLX_IDLE;
			end
		endcase
		n.flux.repeats = s.cfg.repeats;

		// Register writes, settings clamped into range
		if (bus_wr) begin
			if (bus_addr == ADDR_CTRL) begin
				n.cfg.mode = bus_wdata[CTRL_MODE_LSB +: 2];
				n.cfg.tune = bus_wdata[CTRL_TUNE_LSB +: 2];
				n.cfg.hw_chk = bus_wdata[CTRL_HWCHK_BIT];
			end else if (bus_addr == ADDR_ENC) begin
				n.cfg.window = 10'(clamp(16'(bus_wdata[9:0]), 16'(WIN_DEF),
					16'(WIN_MAX)));
				n.cfg.ratio = 9'(clamp(16'(bus_wdata[HI_LSB +: 9]), 16'h0000,
					16'(RATIO_MAX)));
			end else if (bus_addr == ADDR_MOTOR) begin
				n.cfg.slip = 8'(clamp(16'(bus_wdata[7:0]), 16'(SLIP_MIN),
					16'(SLIP_MAX)));
				n.cfg.base = bus_wdata[HI_LSB +: 12];
			end else if (bus_addr == ADDR_DEV) begin
				n.cfg.level = 7'(clamp(16'(bus_wdata[6:0]), 16'h0000,
					16'(LEVEL_MAX)));
				n.cfg.dtime = 14'(clamp(16'(bus_wdata[HI_LSB +: 14]),
					16'h0000, 16'(DTIME_MAX)));
			end else if (bus_addr == ADDR_FLUX) begin
				n.cfg.repeats = 5'(clamp(16'(bus_wdata[4:0]), 16'(REP_MIN),
					16'(REP_MAX)));
				n.flux.pulse_size = 8'(clamp(16'(bus_wdata[FLUX_PULSE_LSB +: 8]),
					16'(PULSE_MIN), 16'(PULSE_MAX)));
				n.flux.current_pct = 8'(clamp(16'(bus_wdata[HI_LSB +: 8]),
					16'(CURR_MIN), 16'(CURR_MAX)));
			end else if (bus_addr == ADDR_REEST) begin
				n.cfg.reest = bus_wdata[15:0];
			end else if (bus_addr == ADDR_TRIP) begin
				n.cfg.trip_mask = bus_wdata[3:0];
			end else if (bus_addr == ADDR_STATUS) begin
				w1c = bus_wdata[ST_W-1:0];
			end else if (bus_addr == ADDR_IRQ_MASK) begin
				n.cfg.irq_mask = bus_wdata[ST_W-1:0];
			end
		end

		// Register reads, answered in the next cycle
		if (bus_rd) begin
			if (bus_addr == ADDR_CTRL) begin
				n.rdata = 32'({s.cfg.hw_chk, s.cfg.tune, s.cfg.mode});
			end else if (bus_addr == ADDR_ENC) begin
				n.rdata = {7'h00, s.cfg.ratio, 6'h00, s.cfg.window};
			end else if (bus_addr == ADDR_MOTOR) begin
				n.rdata = {4'h0, s.cfg.base, 8'h00, s.cfg.slip};
			end else if (bus_addr == ADDR_DEV) begin
				n.rdata = {2'h0, s.cfg.dtime, 9'h000, s.cfg.level};
			end else if (bus_addr == ADDR_FLUX) begin
				n.rdata = {8'h00, s.flux.current_pct, s.flux.pulse_size,
					3'h0, s.cfg.repeats};
			end else if (bus_addr == ADDR_REEST) begin
				n.rdata = {16'h0000, s.cfg.reest};
			end else if (bus_addr == ADDR_TRIP) begin
				n.rdata = 32'(s.cfg.trip_mask);
			end else if (bus_addr == ADDR_STATUS) begin
				n.rdata = 32'(s.status);
			end else if (bus_addr == ADDR_IRQ_MASK) begin
				n.rdata = 32'(s.cfg.irq_mask);
			end else if (bus_addr == ADDR_STATE) begin
				n.rdata = {s.run_cnt, 7'h00, s.flux_init, 4'(s.flx_st),
					1'b0, s.enc_st};
			end
		end

		// Sticky status, a new event beats its own clear
		n.status = (s.status & ~w1c) | ev;
		// Masked faults trip; encoder faults always trip
		n.trip = |(n.status[ST_DEV:ST_OUT_PH] & n.cfg.trip_mask)
			|| n.status[ST_ENC_SW] || n.status[ST_ENC_HW];
		n.irq = |(n.status & n.cfg.irq_mask);
	end

	// Register the whole state, defaults on reset
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s <= '0;
			s.cfg.window <= WIN_DEF;
			s.cfg.ratio <= RATIO_DEF;
			s.cfg.slip <= SLIP_DEF;
			s.cfg.base <= BASE_DEF;
			s.cfg.level <= LEVEL_DEF;
			s.cfg.dtime <= DTIME_DEF;
			s.cfg.repeats <= REP_MIN;
			s.cfg.reest <= REEST_DEF;
			s.cfg.trip_mask <= TRIP_DEF;
			s.flux.pulse_size <= PULSE_DEF;
			s.flux.repeats <= REP_MIN;
			s.flux.current_pct <= CURR_DEF;
			s.enc_st <= ENC_IDLE;
			s.flx_st <= FLX_IDLE;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign bus_rdata = s.rdata;
	assign flux_cmd = s.flux;
	assign drive_trip = s.trip;
	assign irq = s.irq;

	// Checks on the monitor's own behaviour
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	arm_gate_a: assert property (
		s.enc_st == ENC_IDLE && !armed |=> s.enc_st == ENC_IDLE)
		else $error("encoder check left idle while not armed");
	window_range_a: assert property (
		s.cfg.window <= WIN_MAX && s.cfg.ratio <= RATIO_MAX)
		else $error("encoder window or ratio out of range");
	sw_fault_a: assert property (
		s.enc_st == ENC_CHECK && run_cmd && accel_active && shortfall
		|=> s.status[ST_ENC_SW] ##1 drive_trip)
		else $error("encoder fault not flagged after check");
	run_abort_a: assert property (
		s.enc_st == ENC_TIMING && (!run_cmd || !accel_active)
		&& s.cfg.tune == TUNE_NONE |=> s.enc_st == ENC_DONE)
		else $error("encoder check not abandoned");
	check_once_a: assert property (
		s.enc_st == ENC_DONE && run_cmd |=> s.enc_st == ENC_DONE)
		else $error("encoder check repeated within a run");
	slip_wait_a: assert property (
		s.enc_st == ENC_WAIT_SLIP && !slip_ok && run_cmd && accel_active
		&& s.cfg.tune == TUNE_NONE |=> s.enc_st == ENC_WAIT_SLIP)
		else $error("encoder check started below twice slip");
	dev_time_a: assert property (
		excess && !s.dev_fired && s.dev_cnt >= s.cfg.dtime
		|=> s.status[ST_DEV])
		else $error("speed deviation not raised");
	trip_mask_a: assert property (
		$rose(s.status[ST_DEV]) && s.cfg.trip_mask[3] |-> drive_trip)
		else $error("selected deviation fault did not trip");
	no_trip_a: assert property (
		s.status[ST_ENC_HW:ST_OUT_PH] == 6'(1 << ST_DEV)
		&& !s.cfg.trip_mask[3] |-> !drive_trip)
		else $error("unselected fault tripped the drive");
	flux_first_a: assert property (
		run_rise && !s.flux_init && s.flx_st == FLX_IDLE
		|=> flux_cmd.start ##1 !flux_cmd.start)
		else $error("first run did not start flux estimation");
	flux_repeat_a: assert property (
		s.flx_st == FLX_BUSY && flux_pass_done
		&& s.passes + 5'h01 < s.cfg.repeats |=> flux_cmd.start)
		else $error("flux detection pass not repeated");

	enc_fault_c: cover property (s.enc_st == ENC_CHECK ##1 s.status[ST_ENC_SW]);
	enc_abort_c: cover property (s.enc_st == ENC_TIMING ##1 s.enc_st == ENC_DONE);
	dev_trip_c: cover property ($rose(s.status[ST_DEV]) ##1 drive_trip);
	flux_done_c: cover property ($rose(s.status[ST_FLUX_DONE]));
endmodule // encoder_fault_speed_deviation_monitor

// ---- test/encoder_motor_model.sv ----
// Behavioural shaft encoder and motor, plus the flux pass timer.
// Assumes a signed rpm command on core_clk; pins stand still at 0 rpm.
module encoder_motor_model (
	input wire logic core_clk,
	input wire logic signed [15:0] speed_cmd,
	input wire logic miswire,
	input wire logic flux_start,
	output logic enc_a,
	output logic enc_b,
	output logic signed [15:0] speed_meas,
	output logic flux_pass_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] step_div = 2'h0; // Cycles between quadrature steps
	logic [1:0] phase = 2'h0; // Shaft position in quadrature
	logic [2:0] pass_pipe = 3'h0; // Flux pass latency
	logic fwd; // Shaft turns forward as seen by the pins

	// Swapped wiring shows as reversed rotation and negated speed
	assign fwd = (speed_cmd >= 0) ^ miswire;
	assign speed_meas = miswire ? -speed_cmd : speed_cmd;
	assign flux_pass_done = pass_pipe[2];

	// Gray-coded pins from the position count
	always_comb begin
		enc_a = phase[1];
		enc_b = phase[1] ^ phase[0];
	end

	// One step every fourth cycle while turning; pass ends 3 cycles on
	always @(posedge core_clk) begin
		step_div <= step_div + 2'h1;
		if (speed_cmd != 0 && step_div == 2'h3) begin
			phase <= fwd ? phase + 2'h1 : phase - 2'h1;
		end
		pass_pipe <= {pass_pipe[1:0], flux_start};
	end
endmodule // encoder_motor_model

// ---- test/tb_top.sv ----
// Self-checking bench for the encoder and speed supervision block.
// Assumes shortened tick parameters and the encoder model beside it.
`define CHECK(what, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("wrong value %s expected %0h seen %0h", what, exp, got); \
	end \
end

module tb_top
	import efm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] DEV_DEF = 32'h05DC001E; // Default deviation word
	// One supervised run: settings, stimulus, expected {hw, sw, dev}
	typedef struct {
		logic [4:0] ctrl;
		logic [9:0] win;
		logic [31:0] dev;
		logic [15:0] tgt;
		logic [15:0] spd;
		logic mis;
		logic [1:0] ab;
		logic [2:0] exp;
	} case_t;
	logic core_clk, rst_b, bus_wr, bus_rd; // Clock, reset, strobes
	logic [7:0] bus_addr; // Register address
	logic [31:0] bus_wdata, bus_rdata; // Register data
	logic run_cmd, accel_active, miswire; // Run path and wiring fault
	logic signed [15:0] target_speed, speed_cmd, speed_meas; // Speeds
	logic enc_a, enc_b, flux_pass_done, drive_trip, irq; // Model and outputs
	logic [2:0] fault_in; // Magnetic, input phase, output phase
	flux_cmd_t flux_cmd; // Flux engine command
	int n_errors = 0;
	int check_count = 0;
	int n_start = 0; // Flux starts seen
	logic [7:0] def_addr [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
		8'h14, 8'h18, 8'h1C, 8'h20, 8'h28};
	logic [31:0] def_val [10] = '{32'h0, 32'h00FA0000, 32'h07080028,
		DEV_DEF, 32'h00465001, 32'h00000064, 32'h0000000E, 32'h0, 32'h0,
		32'h0};
	logic [7:0] cl_addr [7] = '{8'h04, 8'h0C, 8'h08, 8'h08, 8'h18, 8'h28,
		8'h24};
	logic [31:0] cl_wr [7] = '{32'h01FF03FF, 32'h3FFF007F, 32'h07080000,
		32'h070800FF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
	logic [31:0] cl_exp [7] = '{32'h01F403E8, 32'h270F0064, 32'h0708000A,
		32'h070800FA, 32'h0000000F, 32'h0, 32'h0};
	case_t cases [13] = '{
		'{5'h00,10'h001,DEV_DEF,16'h01F4,16'h012C,1'b1,2'h0,3'h2},
		'{5'h00,10'h001,DEV_DEF,16'h01F4,16'h012C,1'b0,2'h0,3'h0},
		'{5'h00,10'h001,DEV_DEF,16'h01F4,16'h0064,1'b0,2'h0,3'h2},
		'{5'h00,10'h001,DEV_DEF,16'h01F4,16'h012C,1'b1,2'h1,3'h0},
		'{5'h00,10'h001,DEV_DEF,16'h01F4,16'h012C,1'b1,2'h2,3'h0},
		'{5'h04,10'h001,DEV_DEF,16'h01F4,16'h012C,1'b1,2'h0,3'h0},
		'{5'h01,10'h001,DEV_DEF,16'h01F4,16'h012C,1'b1,2'h0,3'h0},
		'{5'h00,10'h000,DEV_DEF,16'h01F4,16'h012C,1'b1,2'h0,3'h0},
		'{5'h00,10'h001,DEV_DEF,16'h0046,16'h012C,1'b1,2'h0,3'h0},
		'{5'h10,10'h000,DEV_DEF,16'h01F4,16'h0000,1'b0,2'h0,3'h4},
		'{5'h10,10'h000,DEV_DEF,16'h01F4,16'h012C,1'b0,2'h0,3'h0},
		'{5'h00,10'h000,32'h0008001E,16'h01F4,16'h012C,1'b1,2'h0,3'h1},
		'{5'h00,10'h000,32'h00080028,16'h01F4,16'h012C,1'b1,2'h0,3'h0}
	};

	encoder_fault_speed_deviation_monitor #(.TICK_CYCLES(10), .STALL_MS(3))
		dut (.core_clk(core_clk), .rst_b(rst_b), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .run_cmd(run_cmd),
		.accel_active(accel_active), .target_speed(target_speed),
		.speed_cmd(speed_cmd), .speed_meas(speed_meas), .enc_a(enc_a),
		.enc_b(enc_b), .out_phase_loss(fault_in[0]),
		.in_phase_loss(fault_in[1]), .mag_detect_err(fault_in[2]),
		.flux_pass_done(flux_pass_done), .flux_cmd(flux_cmd),
		.drive_trip(drive_trip), .irq(irq));

	encoder_motor_model motor (.core_clk(core_clk), .speed_cmd(speed_cmd),
		.miswire(miswire), .flux_start(flux_cmd.start), .enc_a(enc_a),
		.enc_b(enc_b), .speed_meas(speed_meas),
		.flux_pass_done(flux_pass_done));

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Count flux start pulses
	always @(posedge core_clk) begin
		if (flux_cmd.start === 1'b1) begin
			n_start <= n_start + 1;
		end
	end

	// Verdict and end of run
	task automatic end_of_test();
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		@(negedge core_clk);
		d = bus_rdata;
	endtask

	task automatic read_check(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		bus_read(a, d);
		`CHECK("read data", e, d)
	endtask

	task automatic settle();
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic check_flux(input logic [4:0] r, input logic [7:0] p,
		input logic [7:0] c);
		`CHECK("flux repeats", r, flux_cmd.repeats)
		`CHECK("flux pulse", p, flux_cmd.pulse_size)
		`CHECK("flux current", c, flux_cmd.current_pct)
	endtask

	task automatic run_pulse();
		@(posedge core_clk);
		run_cmd <= 1'b1;
		repeat (20) @(posedge core_clk);
		run_cmd <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask

	task automatic run_case(input case_t c);
		logic [31:0] st;
		bus_write(ADDR_CTRL, {27'h0, c.ctrl});
		bus_write(ADDR_ENC, {16'h00FA, 6'h00, c.win});
		bus_write(ADDR_DEV, c.dev);
		@(posedge core_clk);
		target_speed <= c.tgt;
		speed_cmd <= c.spd;
		miswire <= c.mis;
		accel_active <= 1'b1;
		run_cmd <= 1'b1;
		repeat (40) @(posedge core_clk);
		bus_read(ADDR_STATUS, st);
		`CHECK("early status", 2'h0, st[4:3])
		@(posedge core_clk);
		if (c.ab == 2'h1) begin
			run_cmd <= 1'b0;
		end
		if (c.ab == 2'h2) begin
			accel_active <= 1'b0;
		end
		repeat (260) @(posedge core_clk);
		bus_read(ADDR_STATUS, st);
		`CHECK("fault status", c.exp, {st[5], st[4], st[3]})
		`CHECK("trip output", |c.exp, drive_trip)
		`CHECK("masked interrupt", 1'b0, irq)
		@(posedge core_clk);
		run_cmd <= 1'b0;
		accel_active <= 1'b0;
		bus_write(ADDR_STATUS, 32'h0000007F);
		repeat (4) @(posedge core_clk);
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		end_of_test();
	end

	// Main sequence
	initial begin
		rst_b = 1'b0;
		{bus_wr, bus_rd, run_cmd, accel_active, miswire} = 5'h00;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		target_speed = 16'sh0000;
		speed_cmd = 16'sh0000;
		fault_in = 3'h0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		check_flux(5'h01, 8'h50, 8'h46);
		for (int i = 0; i < 10; i++) begin
			read_check(def_addr[i], def_val[i]);
		end
		for (int i = 0; i < 7; i++) begin
			bus_write(cl_addr[i], cl_wr[i]);
			read_check(cl_addr[i], cl_exp[i]);
		end
		for (int i = 0; i < 10; i++) begin
			bus_write(def_addr[i], def_val[i]);
		end
		// Flux settings clamp at both ends
		bus_write(ADDR_FLUX, 32'h00000000);
		settle();
		check_flux(5'h01, 8'h32, 8'h0A);
		bus_write(ADDR_FLUX, 32'h00FFFF1F);
		settle();
		check_flux(5'h1E, 8'hC8, 8'h96);
		bus_write(ADDR_FLUX, 32'h00465001);
		// First run estimates, then every second run
		run_pulse();
		`CHECK("flux starts", 1, n_start)
		read_check(ADDR_STATUS, 32'h00000040);
		bus_write(ADDR_STATUS, 32'h0000007F);
		bus_write(ADDR_REEST, 32'h00000002);
		run_pulse();
		`CHECK("flux starts", 1, n_start)
		// Third run estimates again, now with two detection passes
		bus_write(ADDR_FLUX, 32'h00465002);
		run_pulse();
		`CHECK("flux starts", 3, n_start)
		read_check(ADDR_STATUS, 32'h00000040);
		bus_write(ADDR_STATUS, 32'h0000007F);
		bus_write(ADDR_REEST, 32'h00000064);
		// Each phase or magnetic fault against its mask bit
		for (int i = 0; i < 3; i++) begin
			bus_write(ADDR_IRQ_MASK, 32'h00000001 << i);
			for (int sel = 0; sel < 2; sel++) begin
				bus_write(ADDR_TRIP, sel ? (32'h00000001 << i) :
					(32'h0000000F ^ (32'h00000001 << i)));
				@(posedge core_clk);
				fault_in[i] <= 1'b1;
				@(posedge core_clk);
				fault_in <= 3'h0;
				settle();
				`CHECK("trip output", sel[0], drive_trip)
				`CHECK("interrupt", 1'b1, irq)
				read_check(ADDR_STATUS, 32'h00000001 << i);
				bus_write(ADDR_STATUS, 32'h0000007F);
				settle();
				`CHECK("trip output", 1'b0, drive_trip)
				`CHECK("interrupt", 1'b0, irq)
			end
		end
		bus_write(ADDR_TRIP, 32'h0000000E);
		bus_write(ADDR_IRQ_MASK, 32'h00000000);
		// Supervised runs
		for (int i = 0; i < 13; i++) begin
			run_case(cases[i]);
		end
		// Unselected deviation fault is kept but does not trip
		bus_write(ADDR_TRIP, 32'h00000007);
		bus_write(ADDR_DEV, 32'h0008001E);
		repeat (120) @(posedge core_clk);
		read_check(ADDR_STATUS, 32'h00000008);
		`CHECK("trip output", 1'b0, drive_trip)
		bus_write(ADDR_TRIP, 32'h0000000E);
		settle();
		`CHECK("trip output", 1'b1, drive_trip)
		end_of_test();
	end
endmodule // tb_top
